// ===== pkg/acs_pkg.sv
// Shared constants, types and decode helpers for the converter select block.
package acs_pkg;

	// Register bus geometry.
	localparam int ACS_ADDR_W = 4;
	localparam int ACS_DATA_W = 8;

	// Register offsets.
	localparam logic [3:0] ACS_OFF_INPUT_SELECT = 4'h0;
	localparam logic [3:0] ACS_OFF_RESULT_LOW   = 4'h1;
	localparam logic [3:0] ACS_OFF_RESULT_HIGH  = 4'h2;
	localparam logic [3:0] ACS_OFF_STATUS       = 4'h3;

	// Input select register layout and reset value.
	localparam int ACS_REF_HI   = 7;
	localparam int ACS_REF_LO   = 6;
	localparam int ACS_LADJ_BIT = 5;
	localparam int ACS_CHAN_HI  = 4;
	localparam logic [7:0] ACS_INPUT_SELECT_RST = 8'h00;

	// Status register layout.
	localparam int ACS_STAT_DONE_BIT = 0;
	localparam int ACS_STAT_BUSY_BIT = 1;
	localparam int ACS_STAT_LOCK_BIT = 2;

	// Result coding.
	localparam int ACS_RES_W = 10;
	localparam logic [9:0] ACS_RES_RST     = 10'h000;
	localparam logic [9:0] ACS_SE_MIN      = 10'h000;
	localparam logic [9:0] ACS_SE_MAX      = 10'h3FF;
	localparam logic [9:0] ACS_DIFF_MAX    = 10'h1FF;
	localparam logic [9:0] ACS_DIFF_MIN    = 10'h200;
	localparam int ACS_SE_SHIFT   = 10;
	localparam int ACS_DIFF_SHIFT = 9;

	// Voltages in millivolts.
	localparam int ACS_MV_W = 16;
	localparam logic [15:0] ACS_INT_REF_MV  = 16'h0A00;
	localparam logic [15:0] ACS_BANDGAP_MV  = 16'h04CE;
	localparam logic [15:0] ACS_GROUND_MV   = 16'h0000;

	// Gain factors.
	localparam logic [7:0] ACS_GAIN_1   = 8'h01;
	localparam logic [7:0] ACS_GAIN_10  = 8'h0A;
	localparam logic [7:0] ACS_GAIN_200 = 8'hC8;

	// Channel code groups and special codes.
	localparam logic [1:0] ACS_GRP_SINGLE  = 2'h0;
	localparam logic [1:0] ACS_GRP_GAIN    = 2'h1;
	localparam logic [1:0] ACS_GRP_NEG1    = 2'h2;
	localparam logic [4:0] ACS_CODE_BANDGAP = 5'h1E;
	localparam logic [4:0] ACS_CODE_GROUND  = 5'h1F;
	localparam logic [2:0] ACS_NEG_ONE      = 3'h1;
	localparam logic [2:0] ACS_NEG_TWO      = 3'h2;

	// Reference selection codes.
	typedef enum logic [1:0] {
		ACS_REF_EXT_PIN  = 2'h0,
		ACS_REF_SUPPLY   = 2'h1,
		ACS_REF_RESERVED = 2'h2,
		ACS_REF_INTERNAL = 2'h3
	} acs_ref_t;

	typedef enum logic [1:0] {
		ACS_KIND_SINGLE  = 2'h0,
		ACS_KIND_DIFF    = 2'h1,
		ACS_KIND_BANDGAP = 2'h2,
		ACS_KIND_GROUND  = 2'h3
	} acs_kind_t;

	// Software view of the input select register.
	typedef struct packed {
		logic [1:0] ref_sel;
		logic       left_adjust;
		logic [4:0] chan_gain;
	} acs_select_t;

	// Decoded analog routing.
	typedef struct packed {
		acs_kind_t  kind;
		logic [2:0] pos;
		logic [2:0] neg;
		logic [7:0] gain;
	} acs_route_t;

	typedef logic [7:0][15:0] acs_chan_mv_t;

	// Channel and gain code to routing.
	function automatic acs_route_t acs_decode(input logic [4:0] c);
		acs_route_t r;
		r.kind = ACS_KIND_SINGLE;
		r.pos  = c[2:0];
		r.neg  = c[2:0];
		r.gain = ACS_GAIN_1;
		case (c[4:3])
			ACS_GRP_SINGLE:
				r.kind = ACS_KIND_SINGLE;
			ACS_GRP_GAIN:
			begin
				r.kind = ACS_KIND_DIFF;
				r.pos  = {1'b0, c[2], c[0]};
				r.neg  = {1'b0, c[2], 1'b0};
				r.gain = c[1] ? ACS_GAIN_200 : ACS_GAIN_10;
			end
			ACS_GRP_NEG1:
			begin
				r.kind = ACS_KIND_DIFF;
				r.neg  = ACS_NEG_ONE;
			end
			default:
			begin
				if (c == ACS_CODE_BANDGAP)
					r.kind = ACS_KIND_BANDGAP;
				else if (c == ACS_CODE_GROUND)
					r.kind = ACS_KIND_GROUND;
				else
				begin
					r.kind = ACS_KIND_DIFF;
					r.neg  = ACS_NEG_TWO;
				end
			end
		endcase
		return r;
	endfunction

	// Result to one data byte, aligned as asked.
	function automatic logic [7:0] acs_format(input logic [9:0] res,
		input logic left_adjust, input logic high);
		logic [15:0] word;
		word = left_adjust ? {res, 6'h00} : {6'h00, res};
		return high ? word[15:8] : word[7:0];
	endfunction

endpackage

// ===== hw/acs_result_calc.sv
// Arithmetic that turns the routed input voltages into a result code.
`timescale 1ns/1ps
module acs_result_calc (
	// Routing and reference.
	input  wire acs_pkg::acs_route_t   route_in,
	input  wire acs_pkg::acs_ref_t     ref_sel_in,
	// Analog values in millivolts.
	input  wire acs_pkg::acs_chan_mv_t chan_mv_in,
	input  wire logic [15:0]           ext_ref_mv_in,
	input  wire logic [15:0]           supply_mv_in,
	// Code for the current routing.
	output logic [9:0]                 code_out
);
	import acs_pkg::*;

	logic        [15:0] vref;
	logic        [15:0] vin;
	logic        [25:0] se_num;
	logic        [25:0] se_q;
	logic signed [39:0] diff;
	logic signed [39:0] prod;
	logic signed [39:0] dq;

	always_comb
	begin
		case (ref_sel_in)
			ACS_REF_SUPPLY:   vref = supply_mv_in;
			ACS_REF_INTERNAL: vref = ACS_INT_REF_MV;
			default:          vref = ext_ref_mv_in;
		endcase
	end

	always_comb
	begin
		case (route_in.kind)
			ACS_KIND_BANDGAP: vin = ACS_BANDGAP_MV;
			ACS_KIND_GROUND:  vin = ACS_GROUND_MV;
			default:          vin = chan_mv_in[route_in.pos];
		endcase
	end

	always_comb
	begin
		se_num = {vin, 10'h000}; // [R1]
		se_q   = (vref == 16'h0000) ? 26'h3FFFFFF : se_num / {10'h000, vref};
		diff   = $signed({24'h000000, chan_mv_in[route_in.pos]})
			- $signed({24'h000000, chan_mv_in[route_in.neg]});
		prod   = (diff * $signed({32'h00000000, route_in.gain}))
			<<< ACS_DIFF_SHIFT; // [R3]
		dq     = (vref == 16'h0000) ? prod : prod / $signed({24'h000000, vref});
		if (route_in.kind == ACS_KIND_DIFF)
		begin
			if (dq >= $signed(40'sd511))
				code_out = ACS_DIFF_MAX; // [R5]
			else if (dq <= -$signed(40'sd512))
				code_out = ACS_DIFF_MIN; // [R5]
			else
				code_out = dq[9:0]; // [R4] [R6]
		end
		else if (se_q > {16'h0000, ACS_SE_MAX})
			code_out = ACS_SE_MAX; // [R2]
		else
			code_out = se_q[9:0]; // [R2]
	end

endmodule

// ===== hw/acs_input_select.sv
// Input select register, routing control and result formatting.
`timescale 1ns/1ps
// Contract
// [R1] Single-ended code is input times 1024 over reference, truncated.
// [R2] Single-ended ground codes zero; reference minus one step codes maximum.
// [R3] Differential code is difference times gain times 512 over reference.
// [R4] Differential results are 10-bit two's complement from -512 to +511.
// [R5] Differential inputs beyond full scale clamp to the extreme codes.
// [R6] Top result bit is the sign of a differential result.
// [R7] Result registers hold a valid result once the done flag is set.
// [R8] Select: reference 7:6, left adjust 5, channel code 4:0, reset zero.
// [R9] Reference codes: external pin, supply, reserved, internal 2.56V.
// [R10] Reference and channel writes during a conversion apply at completion.
// [R11] Left adjust one aligns result left in 16 bits, zero aligns right.
// [R12] Left adjust change reformats the presented result at once.
// [R13] Codes 0 to 7 single-ended inputs; 11110 bandgap; 11111 ground.
// [R14] Codes 01000 to 01111 are gain pairs at 10x or 200x.
// [R15] Codes 10000 to 11101 are unity gain pairs against inputs 1 or 2.
// [R16] Software may measure and subtract offset using equal inputs.
// [R17] After a low byte read the result holds until the high byte read.
// [R18] Byte layout of the result for left and right alignment.
// [R19] The reserved reference code is stored like any other value.
module acs_input_select (
	// Clock and reset.
	input  wire logic                  clk_in,
	input  wire logic                  srst_in,
	// Register port.
	input  wire logic [3:0]            addr_in,
	input  wire logic [7:0]            wdata_in,
	input  wire logic                  wr_in,
	input  wire logic                  rd_in,
	output logic [7:0]                 rdata_out,
	// Conversion sequencer.
	input  wire logic                  conv_busy_in,
	input  wire logic                  conv_done_in,
	// Analog values in millivolts.
	input  wire acs_pkg::acs_chan_mv_t chan_mv_in,
	input  wire logic [15:0]           ext_ref_mv_in,
	input  wire logic [15:0]           supply_mv_in,
	// Analog routing.
	output acs_pkg::acs_ref_t          ref_sel_out,
	output acs_pkg::acs_route_t        route_out,
	// Result and flag.
	output logic [9:0]                 result_out,
	output logic                       done_flag_out
);
	import acs_pkg::*;

	acs_select_t sel_r;
	acs_ref_t    ref_r;
	acs_route_t  route_r;
	logic [9:0]  result_r;
	logic        lock_r;
	logic        done_r;
	logic [7:0]  rdata_r;
	logic [9:0]  calc_code;
	logic        wr_sel;
	logic        wr_stat;
	logic        rd_low;
	logic        rd_high;

	assign wr_sel  = wr_in && (addr_in == ACS_OFF_INPUT_SELECT);
	assign wr_stat = wr_in && (addr_in == ACS_OFF_STATUS);
	assign rd_low  = rd_in && (addr_in == ACS_OFF_RESULT_LOW);
	assign rd_high = rd_in && (addr_in == ACS_OFF_RESULT_HIGH);

	acs_result_calc u_calc (
		.route_in      (route_r),
		.ref_sel_in    (ref_r),
		.chan_mv_in    (chan_mv_in),
		.ext_ref_mv_in (ext_ref_mv_in),
		.supply_mv_in  (supply_mv_in),
		.code_out      (calc_code)
	);

	// Software copy of the select register.
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			sel_r <= acs_select_t'(ACS_INPUT_SELECT_RST); // [R8]
		else if (wr_sel)
			sel_r <= acs_select_t'(wdata_in); // [R8] [R19]
	end

	// Active routing follows the copy outside a conversion and in the cycle that completes one.
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			ref_r   <= ACS_REF_EXT_PIN;
			route_r <= acs_decode(ACS_INPUT_SELECT_RST[ACS_CHAN_HI:0]);
		end
		else if (!conv_busy_in || conv_done_in) // [R10]
		begin
			ref_r   <= acs_ref_t'(sel_r.ref_sel); // [R9]
			route_r <= acs_decode(sel_r.chan_gain); // [R13] [R14] [R15]
		end
	end

	// Result capture, held while a low byte read awaits its high byte.
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			result_r <= ACS_RES_RST;
		else if (conv_done_in && !lock_r) // [R17]
			result_r <= calc_code; // [R7]
	end

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			lock_r <= 1'b0;
		else if (rd_low)
			lock_r <= 1'b1; // [R17]
		else if (rd_high)
			lock_r <= 1'b0; // [R17]
	end

	// Done flag: a completion beats a clear in the same cycle.
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			done_r <= 1'b0;
		else if (conv_done_in)
			done_r <= 1'b1; // [R7]
		else if (wr_stat && wdata_in[ACS_STAT_DONE_BIT])
			done_r <= 1'b0;
	end

	// Read data, formatted from the live alignment bit.
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			rdata_r <= 8'h00;
		else if (rd_in)
		begin
			case (addr_in)
				ACS_OFF_INPUT_SELECT:
					rdata_r <= sel_r;
				ACS_OFF_RESULT_LOW:
					rdata_r <= acs_format(result_r, sel_r.left_adjust,
						1'b0); // [R11] [R12] [R18]
				ACS_OFF_RESULT_HIGH:
					rdata_r <= acs_format(result_r, sel_r.left_adjust,
						1'b1); // [R11] [R12] [R18] [R6]
				ACS_OFF_STATUS:
					rdata_r <= {5'h00, lock_r, conv_busy_in, done_r};
				default:
					rdata_r <= 8'h00;
			endcase
		end
		else
			rdata_r <= 8'h00;
	end

	assign rdata_out     = rdata_r;
	assign ref_sel_out   = ref_r;
	assign route_out     = route_r;
	assign result_out    = result_r;
	assign done_flag_out = done_r;

endmodule

// ===== verification/acs_analog_model.sv
// Fixed analog pin and reference voltages in millivolts.
`timescale 1ns/1ps
module acs_analog_model (
	// Pin and reference levels.
	output acs_pkg::acs_chan_mv_t	chan_mv_out,
	output logic [15:0]		ext_ref_mv_out,
	output logic [15:0]		supply_mv_out
);
	import acs_pkg::*;
	assign chan_mv_out = {16'h07FF, 16'h0000, 16'h0000, 16'h0000,
		16'h012C, 16'h01F4, 16'h0064, 16'h0000};
	assign ext_ref_mv_out = 16'h0800;
	assign supply_mv_out = 16'h1388;
endmodule

// ===== verification/acs_input_select_assertions.sv
// Concurrent checks on the converter select block ports.
`timescale 1ns/1ps
module acs_input_select_checker
	import acs_pkg::*;
(
	input wire logic		clk_in,
	input wire logic		srst_in,
	input wire logic [3:0]		addr_in,
	input wire logic [7:0]		wdata_in,
	input wire logic		wr_in,
	input wire logic		rd_in,
	input wire logic [7:0]		rdata_out,
	input wire logic		conv_busy_in,
	input wire logic		conv_done_in,
	input wire acs_pkg::acs_ref_t	ref_sel_out,
	input wire acs_pkg::acs_route_t	route_out,
	input wire logic [9:0]		result_out,
	input wire logic		done_flag_out
);
	logic	lock_r;
	logic	ladj_r;
	always_ff @(posedge clk_in)
		if (srst_in)
			lock_r <= 1'b0;
		else if (rd_in && addr_in == ACS_OFF_RESULT_LOW)
			lock_r <= 1'b1;
		else if (rd_in && addr_in == ACS_OFF_RESULT_HIGH)
			lock_r <= 1'b0;
	always_ff @(posedge clk_in)
		if (srst_in)
			ladj_r <= 1'b0;
		else if (wr_in && addr_in == ACS_OFF_INPUT_SELECT)
			ladj_r <= wdata_in[ACS_LADJ_BIT];
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (srst_in);
	chk_reset_values: assert property ($fell(srst_in) |->
		result_out == 10'h000 && !done_flag_out && ref_sel_out == 2'h0)
		else $error("state after reset wrong");
	chk_done_sets: assert property (conv_done_in |=> done_flag_out)
		else $error("done flag not set");
	chk_result_hold: assert property (!conv_done_in |=>
		$stable(result_out))
		else $error("result moved without done");
	chk_route_hold: assert property (conv_busy_in && !conv_done_in |=>
		$stable(route_out) && $stable(ref_sel_out))
		else $error("routing moved during conversion");
	chk_ref_follow: assert property (wr_in
		&& addr_in == ACS_OFF_INPUT_SELECT && !conv_busy_in ##1 !conv_busy_in
		|=> ref_sel_out == $past(wdata_in[7:6], 2))
		else $error("reference not applied");
	chk_lock_hold: assert property (lock_r && conv_done_in &&
		!(rd_in && addr_in == ACS_OFF_RESULT_HIGH) |=> $stable(result_out))
		else $error("locked result overwritten");
	chk_read_high: assert property (rd_in
		&& addr_in == ACS_OFF_RESULT_HIGH && !conv_done_in |=>
		rdata_out == ($past(ladj_r) ? $past(result_out[9:2])
		: {6'h00, $past(result_out[9:8])}))
		else $error("high byte wrong");
	chk_read_low: assert property (rd_in
		&& addr_in == ACS_OFF_RESULT_LOW && !conv_done_in |=>
		rdata_out == ($past(ladj_r) ? {$past(result_out[1:0]), 6'h00}
		: $past(result_out[7:0])))
		else $error("low byte wrong");
endmodule
bind acs_input_select acs_input_select_checker u_chk (.clk_in, .srst_in,
	.addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .conv_busy_in,
	.conv_done_in, .ref_sel_out, .route_out, .result_out, .done_flag_out);

// ===== verification/tb.sv
// Self-checking bench for the converter select block.
`timescale 1ns/1ps
module tb;
	import acs_pkg::*;
	logic		clk_in, srst_in, wr_in, rd_in;
	logic		conv_busy_in, conv_done_in, done_flag_out;
	logic [3:0]	addr_in;
	logic [7:0]	wdata_in, rdata_out;
	logic [9:0]	result_out;
	logic [15:0]	ext_ref_mv_in, supply_mv_in;
	acs_ref_t	ref_sel_out;
	acs_route_t	route_out, got_rt;
	acs_chan_mv_t	chan_mv_in;
	int		num_errors, tests_run;
	logic [7:0]	sel_tab [11];
	logic [9:0]	res_tab [11];
	logic [15:0]	rte_tab [11];
	acs_analog_model u_pins (.chan_mv_out(chan_mv_in),
		.ext_ref_mv_out(ext_ref_mv_in), .supply_mv_out(supply_mv_in));
	acs_input_select DUT (.clk_in, .srst_in, .addr_in, .wdata_in, .wr_in,
		.rd_in, .rdata_out, .conv_busy_in, .conv_done_in, .chan_mv_in,
		.ext_ref_mv_in, .supply_mv_in, .ref_sel_out, .route_out,
		.result_out, .done_flag_out);
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		chk_word({8'h00, got}, {8'h00, exp});
	endtask
	task automatic chk_ref(input acs_ref_t got, input acs_ref_t exp);
		chk_byte({6'h00, got}, {6'h00, exp});
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_in);
		wr_in <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		chk_byte(rdata_out, e);
	endtask
	task automatic chk_res(input logic [9:0] r, input logic l);
		logic [15:0] w;
		w = l ? {r, 6'h00} : {6'h00, r};
		chk_word({6'h00, result_out}, {6'h00, r});
		rd(ACS_OFF_RESULT_LOW, w[7:0]);
		rd(ACS_OFF_RESULT_HIGH, w[15:8]);
	endtask
	task automatic go;
		@(posedge clk_in);
		conv_busy_in <= 1'b1;
	endtask
	task automatic fin;
		repeat (2) @(posedge clk_in);
		conv_done_in <= 1'b1;
		@(posedge clk_in);
		conv_done_in <= 1'b0;
		conv_busy_in <= 1'b0;
		#1;
	endtask
	task automatic test_done;
		$display("compares %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	initial
	begin
		repeat (2000) @(posedge clk_in);
		num_errors++;
		test_done();
	end
	initial
	begin
		{wr_in, rd_in, conv_busy_in, conv_done_in} = 4'h0;
		addr_in = 4'h0;
		wdata_in = 8'h00;
		num_errors = 0;
		tests_run = 0;
		srst_in = 1'b1;
		sel_tab = '{8'h03, 8'h07, 8'h1F, 8'h5E, 8'hED, 8'hCD,
			8'hCF, 8'hCB, 8'hD8, 8'hD0, 8'hC8};
		res_tab = '{10'h096, 10'h3FF, 10'h000, 10'h0FB, 10'h270, 10'h270,
			10'h200, 10'h1FF, 10'h39C, 10'h3EC, 10'h000};
		rte_tab = '{16'h1800, 16'h3800, 16'hC000, 16'h8000, 16'h5A0A,
			16'h5A0A, 16'h5AC8, 16'h48C8, 16'h4201, 16'h4101, 16'h400A};
		repeat (5) @(posedge clk_in);
		srst_in <= 1'b0;
		rd(ACS_OFF_INPUT_SELECT, ACS_INPUT_SELECT_RST);
		rd(4'hF, 8'h00);
		for (int r = 0; r < 4; r++)
		begin
			wr(ACS_OFF_INPUT_SELECT, {r[1:0], 6'h25});
			rd(ACS_OFF_INPUT_SELECT, {r[1:0], 6'h25});
			chk_ref(ref_sel_out, acs_ref_t'(r[1:0]));
		end
		$display("test register done");
		for (int i = 0; i < 11; i++)
		begin
			wr(ACS_OFF_INPUT_SELECT, sel_tab[i]);
			go();
			fin();
			got_rt = route_out;
			if (rte_tab[i][15:14] != ACS_KIND_DIFF)
			begin
				got_rt.neg = 3'h0;
				got_rt.gain = 8'h00;
			end
			if (rte_tab[i][15])
				got_rt.pos = 3'h0;
			chk_word(got_rt, rte_tab[i]);
			chk_res(res_tab[i], sel_tab[i][5]);
		end
		chk_byte({7'h00, done_flag_out}, 8'h01);
		rd(ACS_OFF_STATUS, 8'h01);
		wr(ACS_OFF_STATUS, 8'h01);
		chk_byte({7'h00, done_flag_out}, 8'h00);
		rd(ACS_OFF_STATUS, 8'h00);
		$display("test coding done");
		wr(ACS_OFF_INPUT_SELECT, 8'h03);
		go();
		wr(ACS_OFF_INPUT_SELECT, 8'hED);
		chk_ref(ref_sel_out, ACS_REF_EXT_PIN);
		fin();
		chk_ref(ref_sel_out, ACS_REF_INTERNAL);
		chk_res(10'h096, 1'b1);
		go();
		wr(ACS_OFF_INPUT_SELECT, 8'hCD);
		chk_res(10'h096, 1'b0);
		fin();
		rd(ACS_OFF_RESULT_LOW, 8'h70);
		wr(ACS_OFF_INPUT_SELECT, 8'hCB);
		go();
		fin();
		rd(ACS_OFF_RESULT_HIGH, 8'h02);
		go();
		fin();
		chk_res(10'h1FF, 1'b0);
		$display("test timing done");
		test_done();
	end
endmodule
